// ==== rtl/reg_math_pkg.sv ====
// Shared constants and types for the register load and math unit
package reg_math_pkg;
    localparam int DATA_W = 32;
    localparam int SEL_W = 6;
    localparam int NUM_REGS = 64;
    localparam logic [SEL_W-1:0] ACC_SEL = 6'h00;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam int HALF_W = 16;
    localparam int DIV_STEPS = 32;
    localparam logic [5:0] DIV_CNT_LAST = 6'h1F;

    typedef enum logic [2:0] {
        OP_LOAD = 3'b000,
        OP_READ = 3'b001,
        OP_ADD  = 3'b010,
        OP_SUB  = 3'b011,
        OP_MUL  = 3'b100,
        OP_DIV  = 3'b101,
        OP_AND  = 3'b110
    } op_t;

    typedef struct packed {
        op_t op;
        logic [SEL_W-1:0] sel_a;
        logic [SEL_W-1:0] sel_b;
        logic [DATA_W-1:0] value;
    } cmd_t;

    typedef struct packed {
        logic cc_true;
        logic cc_false;
        logic cc_neg;
        logic cc_pos;
        logic cc_zero;
    } cond_t;
endpackage : reg_math_pkg

// ==== rtl/seq_divider.sv ====
// Sequential signed 32-bit restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
`default_nettype none
module seq_divider
    import reg_math_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Operands
    input wire logic start,
    input wire logic [DATA_W-1:0] dividend,
    input wire logic [DATA_W-1:0] divisor,
    // Result
    output logic done,
    output logic [DATA_W-1:0] quotient
);
    logic busy_r, busy_nxt, done_r, done_nxt, neg_r, neg_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [DATA_W-1:0] q_r, q_nxt, d_r, d_nxt;
    logic [DATA_W:0] rem_r, rem_nxt, trial;

    always_comb begin
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        neg_nxt = neg_r;
        cnt_nxt = cnt_r;
        q_nxt = q_r;
        d_nxt = d_r;
        rem_nxt = rem_r;
        trial = {rem_r[DATA_W-1:0], q_r[DATA_W-1]} - {1'b0, d_r};
        if (start) begin
            busy_nxt = 1'b1;
            cnt_nxt = 6'h00;
            neg_nxt = dividend[DATA_W-1] ^ divisor[DATA_W-1];
            q_nxt = dividend[DATA_W-1] ? -dividend : dividend;
            d_nxt = divisor[DATA_W-1] ? -divisor : divisor;
            rem_nxt = '0;
        end else if (busy_r) begin
            if (trial[DATA_W]) begin
                rem_nxt = {rem_r[DATA_W-1:0], q_r[DATA_W-1]};
                q_nxt = {q_r[DATA_W-2:0], 1'b0};
            end else begin
                rem_nxt = trial;
                q_nxt = {q_r[DATA_W-2:0], 1'b1};
            end
            cnt_nxt = 6'(cnt_r + 6'h01);
            if (cnt_r == DIV_CNT_LAST) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                if (neg_r) q_nxt = -q_nxt;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            neg_r <= 1'b0;
            cnt_r <= 6'h00;
            q_r <= ZERO_WORD;
            d_r <= ZERO_WORD;
            rem_r <= '0;
        end else begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            neg_r <= neg_nxt;
            cnt_r <= cnt_nxt;
            q_r <= q_nxt;
            d_r <= d_nxt;
            rem_r <= rem_nxt;
        end
    end

    assign done = done_r;
    assign quotient = q_r;
endmodule : seq_divider
`default_nettype wire

// ==== rtl/register_load_math_unit.sv ====
// Data register file with buffered load, read-back and accumulator math
// Contract
// - Buffered load writes the given value into the selected register as a long word.
// - Short-word registers keep the low half of the loaded value, sign-extended to 32 bits.
// - Loads pass through the same command queue entry as other buffered commands.
// - Load without value reads back the register; read-only registers allowed here.
// - Add writes first plus second register into accumulator, register zero.
// - Addition is 32-bit and may overflow.
// - Subtract writes first minus second at 32 bits into accumulator.
// - Multiply writes 32-bit product of the two registers into accumulator.
// - Divide writes first divided by second at 32 bits into accumulator.
// - Divide by a zero divisor is ignored entirely.
// - AND writes 32-bit bitwise AND of the two registers into accumulator.
// - Every math operation except an ignored divide by zero updates the jump condition code: T, F, N, P, Z.
`timescale 1ns/1ps
`default_nettype none
module register_load_math_unit
    import reg_math_pkg::*;
#(
    parameter logic [NUM_REGS-1:0] SHORT_MASK = 64'h0000_0000_0000_0000,
    parameter logic [NUM_REGS-1:0] RO_MASK = 64'h0000_0000_0000_0000
)(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Command entry
    input wire logic cmd_valid,
    input wire cmd_t cmd,
    output logic cmd_ready,
    // Read-only register sources
    input wire logic [DATA_W-1:0] ro_value,
    // Results
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    output logic cmd_done,
    output logic div_ignored,
    output logic load_refused,
    output cond_t cond
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DIV  = 2'b10
    } state_t;

    logic [DATA_W-1:0] regs_r [NUM_REGS];
    logic [DATA_W-1:0] regs_nxt [NUM_REGS];
    state_t state_r, state_nxt;
    cmd_t hold_r, hold_nxt;
    cond_t cond_r, cond_nxt;
    logic rd_valid_r, rd_valid_nxt, done_r, done_nxt;
    logic ign_r, ign_nxt, ref_r, ref_nxt, ready_r, ready_nxt;
    logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
    logic [DATA_W-1:0] opa, opb, res;
    logic [2*DATA_W-1:0] prod;
    logic wr_acc, wr_sel, div_start, div_done;
    logic [DATA_W-1:0] quot, load_val;

    seq_divider u_div (
        .clock(clock),
        .rstn(rstn),
        .start(div_start),
        .dividend(opa),
        .divisor(opb),
        .done(div_done),
        .quotient(quot)
    );

    assign opa = regs_r[hold_r.sel_a];
    assign opb = regs_r[hold_r.sel_b];
    assign prod = opa * opb;

    always_comb begin
        state_nxt = state_r;
        hold_nxt = hold_r;
        cond_nxt = cond_r;
        rd_valid_nxt = 1'b0;
        done_nxt = 1'b0;
        ign_nxt = 1'b0;
        ref_nxt = 1'b0;
        ready_nxt = ready_r;
        rd_data_nxt = rd_data_r;
        div_start = 1'b0;
        wr_acc = 1'b0;
        wr_sel = 1'b0;
        res = ZERO_WORD;
        load_val = SHORT_MASK[hold_r.sel_a]
            ? {{HALF_W{hold_r.value[HALF_W-1]}}, hold_r.value[HALF_W-1:0]}
            : hold_r.value;
        unique case (state_r)
            ST_IDLE: begin
                if (cmd_valid && ready_r) begin
                    hold_nxt = cmd;
                    ready_nxt = 1'b0;
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_nxt = ST_IDLE;
                ready_nxt = 1'b1;
                done_nxt = 1'b1;
                case (hold_r.op)
                    OP_LOAD: begin
                        if (RO_MASK[hold_r.sel_a]) ref_nxt = 1'b1;
                        else wr_sel = 1'b1;
                    end
                    OP_READ: begin
                        rd_valid_nxt = 1'b1;
                        rd_data_nxt = RO_MASK[hold_r.sel_a] ? ro_value : opa;
                    end
                    OP_ADD: begin
                        res = opa + opb;
                        wr_acc = 1'b1;
                    end
                    OP_SUB: begin
                        res = opa - opb;
                        wr_acc = 1'b1;
                    end
                    OP_MUL: begin
                        res = prod[DATA_W-1:0];
                        wr_acc = 1'b1;
                    end
                    OP_AND: begin
                        res = opa & opb;
                        wr_acc = 1'b1;
                    end
                    OP_DIV: begin
                        if (opb == ZERO_WORD) begin
                            ign_nxt = 1'b1;
                        end else begin
                            div_start = 1'b1;
                            done_nxt = 1'b0;
                            ready_nxt = 1'b0;
                            state_nxt = ST_DIV;
                        end
                    end
                    default: ref_nxt = 1'b1;
                endcase
            end
            ST_DIV: begin
                if (div_done) begin
                    res = quot;
                    wr_acc = 1'b1;
                    done_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
        if (wr_acc) begin
            cond_nxt.cc_zero = (res == ZERO_WORD);
            cond_nxt.cc_neg = res[DATA_W-1];
            cond_nxt.cc_pos = !res[DATA_W-1] && (res != ZERO_WORD);
            cond_nxt.cc_true = (res != ZERO_WORD);
            cond_nxt.cc_false = (res == ZERO_WORD);
        end
    end

    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
            always_comb begin
                regs_nxt[i] = regs_r[i];
                if (wr_sel && hold_r.sel_a == SEL_W'(i)) regs_nxt[i] = load_val;
                if (wr_acc && SEL_W'(i) == ACC_SEL) regs_nxt[i] = res;
            end
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) regs_r[i] <= ZERO_WORD;
                else regs_r[i] <= regs_nxt[i];
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            hold_r <= '0;
            cond_r <= '0;
            rd_valid_r <= 1'b0;
            done_r <= 1'b0;
            ign_r <= 1'b0;
            ref_r <= 1'b0;
            ready_r <= 1'b1;
            rd_data_r <= ZERO_WORD;
        end else begin
            state_r <= state_nxt;
            hold_r <= hold_nxt;
            cond_r <= cond_nxt;
            rd_valid_r <= rd_valid_nxt;
            done_r <= done_nxt;
            ign_r <= ign_nxt;
            ref_r <= ref_nxt;
            ready_r <= ready_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign cmd_ready = ready_r;
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
    assign cmd_done = done_r;
    assign div_ignored = ign_r;
    assign load_refused = ref_r;
    assign cond = cond_r;

    // Reference model results, kept beside the logic they check
    logic past_exec;
    assign past_exec = (state_r == ST_EXEC);

    sequence s_math_exec;
        past_exec && (hold_r.op inside {OP_ADD, OP_SUB, OP_MUL, OP_AND});
    endsequence

    AST_ADD_RESULT: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_ADD |=> regs_r[ACC_SEL] == $past(opa) + $past(opb))
        else $error("add result wrong");
    AST_ADD_WRAP: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_ADD |=> cmd_done && regs_r[ACC_SEL] == 32'($past(opa) + $past(opb)))
        else $error("add not 32-bit");
    AST_SUB_RESULT: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_SUB |=> regs_r[ACC_SEL] == $past(opa) - $past(opb))
        else $error("subtract result wrong");
    AST_MUL_RESULT: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_MUL |=> regs_r[ACC_SEL] == $past(prod[DATA_W-1:0]))
        else $error("multiply result wrong");
    AST_AND_RESULT: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_AND |=> regs_r[ACC_SEL] == ($past(opa) & $past(opb)))
        else $error("and result wrong");
    AST_DIV_ZERO: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_DIV && opb == ZERO_WORD
        |=> div_ignored && $stable(regs_r[ACC_SEL]) && $stable(cond))
        else $error("divide by zero not ignored");
    AST_DIV_DONE: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_DIV && opb != ZERO_WORD |=> ##[1:40] cmd_done)
        else $error("divide never completes");
    AST_COND_ZERO: assert property (@(posedge clock) disable iff (!rstn)
        s_math_exec |=> cond.cc_zero == (regs_r[ACC_SEL] == ZERO_WORD)
            && cond.cc_neg == regs_r[ACC_SEL][DATA_W-1])
        else $error("condition code mismatch");
    AST_COND_POS: assert property (@(posedge clock) disable iff (!rstn)
        s_math_exec |=> cond.cc_pos == (!regs_r[ACC_SEL][DATA_W-1] && regs_r[ACC_SEL] != ZERO_WORD)
            && cond.cc_true == (regs_r[ACC_SEL] != ZERO_WORD)
            && cond.cc_false == (regs_r[ACC_SEL] == ZERO_WORD))
        else $error("positive, true or false code mismatch");
    AST_LOAD_SHORT: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_LOAD && !RO_MASK[hold_r.sel_a] && SHORT_MASK[hold_r.sel_a]
        && hold_r.sel_a != ACC_SEL |=> regs_r[$past(hold_r.sel_a)][HALF_W-1:0]
            == $past(hold_r.value[HALF_W-1:0]))
        else $error("short load wrong");
    AST_READ_BACK: assert property (@(posedge clock) disable iff (!rstn)
        past_exec && hold_r.op == OP_READ |=> rd_valid && !$stable(rd_valid))
        else $error("read-back missing");
endmodule : register_load_math_unit
`default_nettype wire

// ==== verif/cmd_issuer.sv ====
// Host-side model that issues register commands one at a time
`timescale 1ns/1ps
`default_nettype none
module cmd_issuer
    import reg_math_pkg::*;
(
    // Clock
    input wire logic clock,
    // Command entry
    input wire logic cmd_ready,
    output logic cmd_valid,
    output cmd_t cmd,
    // Status towards the bench
    output logic stuck
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        stuck = 1'b0;
    end

    // Idle fields carry garbage so nothing can lean on stale values
    task automatic release_bus();
        cmd_valid = 1'b0;
        cmd = ~cmd;
    endtask : release_bus

    // One command in flight at a time, as a stored program issues them
    task automatic send(input cmd_t c, input int gap);
        int n;
        n = 0;
        if (gap > 0) begin
            release_bus();
            repeat (gap) @(negedge clock);
        end
        cmd_valid = 1'b1;
        cmd = c;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        if (n >= 100) stuck = 1'b1;
        @(negedge clock);
    endtask : send
endmodule : cmd_issuer
`default_nettype wire

// ==== verif/tb_register_load_math_unit.sv ====
// Self-checking bench for the register load and math unit
`timescale 1ns/1ps
`default_nettype none
module tb_register_load_math_unit
    import reg_math_pkg::*;
;
    typedef struct packed {
        logic rdv;
        logic divi;
        logic refl;
        logic [DATA_W-1:0] data;
        cond_t cc;
    } note_t;
    // Register 5 is short, register 63 is read-only
    localparam logic [NUM_REGS-1:0] SHORTS = 64'h0000_0000_0000_0020;
    localparam logic [NUM_REGS-1:0] ROS = 64'h8000_0000_0000_0000;
    logic clock, rstn, cmd_valid, cmd_ready, rd_valid, cmd_done;
    logic div_ignored, load_refused, stuck;
    cmd_t cmd;
    cond_t cond, cc_exp;
    logic [DATA_W-1:0] ro_value, rd_data;
    logic [DATA_W-1:0] regs [NUM_REGS];
    note_t notes[$];
    note_t mon_note;
    int err_count, check_count, n;

    register_load_math_unit #(.SHORT_MASK(SHORTS), .RO_MASK(ROS)) register_load_math_unit_inst (
        .clock(clock), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .ro_value(ro_value), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_done(cmd_done),
        .div_ignored(div_ignored), .load_refused(load_refused), .cond(cond));
    cmd_issuer cmd_issuer_inst (.clock(clock), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd(cmd), .stuck(stuck));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (err_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // Works out the expected outcome, notes it, then hands the command over
    task automatic do_cmd(input op_t op, input int a, input int b, input logic [31:0] v);
        note_t nt;
        logic [31:0] x, y, r;
        x = regs[a];
        y = regs[b];
        nt = '{rdv: 1'b0, divi: 1'b0, refl: 1'b0, data: '0, cc: cc_exp};
        r = '0;
        case (op)
            OP_LOAD: if (ROS[a]) nt.refl = 1'b1;
                else regs[a] = SHORTS[a] ? {{16{v[15]}}, v[15:0]} : v;
            OP_READ: begin
                nt.rdv = 1'b1;
                nt.data = ROS[a] ? ro_value : regs[a];
            end
            OP_ADD: r = x + y;
            OP_SUB: r = x - y;
            OP_MUL: r = x * y;
            OP_DIV: if (y == 0) nt.divi = 1'b1;
                else r = $signed(x) / $signed(y);
            OP_AND: r = x & y;
            default: nt.refl = 1'b1;
        endcase
        if (op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_AND} && !nt.divi) begin
            regs[0] = r;
            cc_exp = '{r != 0, r == 0, r[31], !r[31] && r != 0, r == 0};
            nt.cc = cc_exp;
        end
        notes.push_back(nt);
        cmd_issuer_inst.send('{op, 6'(a), 6'(b), v}, $urandom_range(2));
    endtask : do_cmd

    // Accumulator is only visible through read-back, so each math op is followed by one
    task automatic math(input op_t op, input int a, input int b);
        do_cmd(op, a, b, 32'h0);
        do_cmd(OP_READ, 0, 0, 32'h0);
    endtask : math

    always @(negedge clock) begin
        if (rstn && cmd_done === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                mon_note = notes.pop_front();
                check(32'(cmd_ready), 32'h1);
                check(32'(rd_valid), 32'(mon_note.rdv));
                check(32'(div_ignored), 32'(mon_note.divi));
                check(32'(load_refused), 32'(mon_note.refl));
                if (mon_note.rdv) check(rd_data, mon_note.data);
                check(32'(cond), 32'(mon_note.cc));
            end
        end
    end

    initial begin
        rstn = 1'b0;
        err_count = 0;
        check_count = 0;
        cc_exp = '0;
        foreach (regs[i]) regs[i] = '0;
        void'($urandom(32'h48EBEF0C));
        ro_value = $urandom;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        do_cmd(OP_LOAD, 1, 0, 32'h7FFF_FFFF);
        do_cmd(OP_LOAD, 2, 0, 32'h0000_0001);
        do_cmd(OP_LOAD, 5, 0, 32'hFFFF_8001);
        do_cmd(OP_LOAD, 63, 0, 32'h0000_0055);
        foreach (regs[i]) if (i inside {1, 2, 5, 63}) do_cmd(OP_READ, i, 0, 32'h0);
        math(OP_ADD, 1, 2);
        math(OP_SUB, 5, 1);
        math(OP_MUL, 1, 1);
        math(OP_DIV, 1, 5);
        do_cmd(OP_LOAD, 3, 0, 32'h0);
        math(OP_DIV, 1, 3);
        math(OP_AND, 1, 5);
        math(OP_AND, 3, 1);
        do_cmd(op_t'(3'h7), 1, 2, 32'h0);
        repeat (40) begin
            n = $urandom;
            if (n == 32'h8000_0000) n = 1;
            do_cmd(OP_LOAD, 1 + $urandom_range(3), 0, 32'(n));
            math(op_t'(3'h2 + 3'($urandom_range(4))), 1 + $urandom_range(3), 1 + $urandom_range(3));
        end
        cmd_issuer_inst.release_bus();
        n = 0;
        while (notes.size() != 0 && n < 200) begin
            @(negedge clock);
            n++;
        end
        check(32'(notes.size()), 32'h0);
        check(32'(stuck), 32'h0);
        print_verdict();
    end
endmodule : tb_register_load_math_unit
`default_nettype wire
